/* core/mmap_decoder.sv */
// Memory-space decoder: program, data, byte and I/O space routing.
// Assumes straps are stable around reset release and pins are asynchronous.
//
// Overview of operation
// - 24-bit program space holding code and data, 8K words on-chip RAM.
// - On-chip program RAM serves fetch and data access in one cycle.
// - Up to two external 8K program overlays via external bus.
// - Layout set by external-code strap and code overlay select.
// - Select zero makes 0x2000-0x3FFF reserved; nonzero sends it external.
// - Overlay 1 drives address MSB low, overlay 2 high; low 13 from core.
// - Overlays use only the ordinary 14 address bits.
// - Sequencer ignores overlay select; loop safety is software's job.
// - Overlay selects are never saved or restored on interrupts.
// - Strap high: no boot, no overlay, low 8K external, upper reserved.
// - 16-bit data space, 8160 words plus 32 mapped registers on chip.
// - Byte memory 8-bit, page on data lines gives 22-bit address.
// - I/O space holds 2048 16-bit locations.
// - Host mode keeps full data bus; program, data and I/O address only on lowest line.
// - After reset, boot if configured and bus free, then start at 0.
// - Data select nonzero sends 0x0000-0x1FFF external, same overlays.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mmap_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_code_strap,
   input wire logic host_mode_pin,
   input wire logic bus_request_pin,
   input wire logic boot_done_pin,
   input wire mmap_pkg::pm_req_t fetch_req,
   input wire mmap_pkg::pm_req_t pm_req,
   input wire mmap_pkg::dm_req_t dm_req,
   input wire mmap_pkg::io_req_t io_req,
   input wire mmap_pkg::bm_req_t bm_req,
   output logic [23:0] fetch_rdata,
   output logic [23:0] pm_rdata,
   output logic [15:0] dm_rdata,
   output logic fetch_stall,
   output mmap_pkg::ext_bus_t pm_ext,
   output mmap_pkg::ext_bus_t dm_ext,
   output mmap_pkg::ext_bus_t io_bus,
   output mmap_pkg::ext_bus_t byte_dma_port,
   output logic dm_mmr_sel,
   output logic [4:0] dm_mmr_index,
   output logic boot_req,
   output logic core_run,
   output logic [13:0] start_addr
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_CAPTURE, ST_WAIT_BUS, ST_BOOT, ST_RUN}
      boot_state_t;
   boot_state_t state_q;
   logic strap_s, host_s, busreq_s, bootdone_s;
   logic strap_q;
   logic [1:0] fill_q;
   logic [3:0] code_overlay_select_q, data_overlay_select_q;
   logic pm_rsv_q, dm_rsv_q;
   mmap_pkg::route_t fetch_rt, pm_rt, dm_rt;
   logic dm_internal, dm_mmr;
   logic apb_wr, apb_rd, hit_code, hit_data, hit_stat;
   logic [15:0] dm_mem [0:8191];
   logic [23:0] fetch_int, pm_int;
   logic fetch_ext_q, pm_ext_rd_q;
   logic [23:0] ext_rd_s;

   ////////////////////////////////////////////////////////////////////////
   // Routing functions shared by both program ports and host masking
   function automatic mmap_pkg::route_t pm_route(input logic [13:0] a,
         input logic [3:0] sel, input logic strap);
      mmap_pkg::route_t r;
      r = '0;
      if (strap) begin
         r.ext = (a < mmap_pkg::UPPER_BASE);
         r.rsv = !r.ext;
      end else if (a >= mmap_pkg::UPPER_BASE) begin
         r.ext = (sel != mmap_pkg::OVL_RST);
         r.rsv = !r.ext;
         r.msb = (sel != mmap_pkg::OVL_ONE);
      end
      return r;
   endfunction

   // Host mode leaves only the lowest address line live
   function automatic logic [13:0] ext_addr(input logic msb,
         input logic [12:0] low, input logic host);
      logic [13:0] a;
      a = {msb, low};
      if (host) begin
         a = {13'h0000, low[0]};
      end
      return a;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   sync2 #(.W(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({ext_code_strap, host_mode_pin, bus_request_pin, boot_done_pin}),
      .dout({strap_s, host_s, busreq_s, bootdone_s})
   );

   sync2 #(.W(24)) u_sync_data (
      .pclk(pclk),
      .presetn(presetn),
      .din(pm_ext.wdata),
      .dout(ext_rd_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped offsets
   assign hit_code = (paddr == mmap_pkg::OFS_CODE_OVL);
   assign hit_data = (paddr == mmap_pkg::OFS_DATA_OVL);
   assign hit_stat = (paddr == mmap_pkg::OFS_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_code || hit_data || hit_stat);
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !pwrite;

   // Selects change by software writes, code select also cleared by the strap; nothing in the core saves them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_overlay_select_q <= mmap_pkg::OVL_RST;
      end else if (strap_q) begin
         code_overlay_select_q <= mmap_pkg::OVL_RST;
      end else if (apb_wr && hit_code) begin
         code_overlay_select_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_overlay_select_q <= mmap_pkg::OVL_RST;
      end else if (apb_wr && hit_data) begin
         data_overlay_select_q <= pwdata[3:0];
      end
   end

   // Sticky reserved-access flags: write one to clear, a new hit wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_rsv_q <= 1'b0;
         dm_rsv_q <= 1'b0;
      end else begin
         if ((fetch_req.en && fetch_rt.rsv) || (pm_req.en && pm_rt.rsv)) begin
            pm_rsv_q <= 1'b1;
         end else if (apb_wr && hit_stat && pwdata[mmap_pkg::ST_PM_RSV_BIT])
         begin
            pm_rsv_q <= 1'b0;
         end
         if (dm_req.en && dm_rt.rsv) begin
            dm_rsv_q <= 1'b1;
         end else if (apb_wr && hit_stat && pwdata[mmap_pkg::ST_DM_RSV_BIT])
         begin
            dm_rsv_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_rd && !penable) begin
         prdata <= 32'h00000000;
         if (hit_code) begin
            prdata[3:0] <= code_overlay_select_q;
         end
         if (hit_data) begin
            prdata[3:0] <= data_overlay_select_q;
         end
         if (hit_stat) begin
            prdata[mmap_pkg::ST_STRAP_BIT] <= strap_q;
            prdata[mmap_pkg::ST_RUN_BIT] <= core_run;
            prdata[mmap_pkg::ST_PM_RSV_BIT] <= pm_rsv_q;
            prdata[mmap_pkg::ST_DM_RSV_BIT] <= dm_rsv_q;
            prdata[mmap_pkg::ST_HOST_BIT] <= host_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchroniser outputs show reset zeros for two edges after release;
   // reading them earlier would lose the strap and fake a free bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_q <= 2'h0;
      end else begin
         fill_q <= {fill_q[0], 1'b1};
      end
   end

   // Strap capture and boot sequence after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_CAPTURE;
         strap_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_CAPTURE: begin
               if (fill_q[1]) begin
                  strap_q <= strap_s;
                  state_q <= strap_s ? ST_RUN : ST_WAIT_BUS;
               end
            end
            ST_WAIT_BUS: begin
               if (!busreq_s) begin
                  state_q <= ST_BOOT;
               end
            end
            ST_BOOT: begin
               if (bootdone_s) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   assign boot_req = (state_q == ST_BOOT);
   assign core_run = (state_q == ST_RUN);
   assign start_addr = mmap_pkg::BOOT_START;

   ////////////////////////////////////////////////////////////////////////
   // Program space: both ports may hit on-chip RAM in the same cycle
   assign fetch_rt = pm_route(fetch_req.addr, code_overlay_select_q, strap_q);
   assign pm_rt = pm_route(pm_req.addr, code_overlay_select_q, strap_q);
   // One external bus: the data access wins, the fetch waits
   assign fetch_stall = fetch_req.en && fetch_rt.ext && pm_req.en && pm_rt.ext;

   pm_ram_dp #(.AW(mmap_pkg::OVL_LOW_W), .DW(mmap_pkg::PM_DW)) u_pm_ram (
      .pclk(pclk),
      .a_en(fetch_req.en && !fetch_rt.ext && !fetch_rt.rsv),
      .a_addr(fetch_req.addr[12:0]),
      .a_rdata(fetch_int),
      .b_en(pm_req.en && !pm_rt.ext && !pm_rt.rsv),
      .b_we(pm_req.we),
      .b_addr(pm_req.addr[12:0]),
      .b_wdata(pm_req.wdata),
      .b_rdata(pm_int)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_ext <= '0;
         fetch_ext_q <= 1'b0;
         pm_ext_rd_q <= 1'b0;
      end else begin
         pm_ext <= '0;
         fetch_ext_q <= fetch_req.en && fetch_rt.ext && !fetch_stall;
         pm_ext_rd_q <= pm_req.en && pm_rt.ext && !pm_req.we;
         if (pm_req.en && pm_rt.ext) begin
            pm_ext.sel <= 1'b1;
            pm_ext.we <= pm_req.we;
            pm_ext.addr <= ext_addr(pm_rt.msb, pm_req.addr[12:0], host_s);
            pm_ext.wdata <= pm_req.wdata;
         end else if (fetch_req.en && fetch_rt.ext) begin
            pm_ext.sel <= 1'b1;
            pm_ext.addr <= ext_addr(fetch_rt.msb, fetch_req.addr[12:0],
                                    host_s);
         end
      end
   end

   // External read data is pm_ext.wdata passed back through a second synchroniser
   assign fetch_rdata = fetch_ext_q ? ext_rd_s : fetch_int;
   assign pm_rdata = pm_ext_rd_q ? ext_rd_s : pm_int;

   ////////////////////////////////////////////////////////////////////////
   // Data space: low 8K overlay, 8160 words RAM, 32 mapped registers
   assign dm_mmr = (dm_req.addr >= mmap_pkg::MMR_BASE);
   assign dm_internal = (dm_req.addr >= mmap_pkg::UPPER_BASE) && !dm_mmr;
   always_comb begin
      dm_rt = '0;
      if (dm_req.addr < mmap_pkg::UPPER_BASE) begin
         dm_rt.ext = (data_overlay_select_q != mmap_pkg::OVL_RST);
         dm_rt.rsv = !dm_rt.ext;
         dm_rt.msb = (data_overlay_select_q != mmap_pkg::OVL_ONE);
      end
   end

   // The RAM is read and written only below the mapped registers
   always_ff @(posedge pclk) begin
      if (dm_req.en && dm_internal) begin
         if (dm_req.we) begin
            dm_mem[dm_req.addr[12:0]] <= dm_req.wdata;
         end
         dm_rdata <= dm_mem[dm_req.addr[12:0]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dm_ext <= '0;
         dm_mmr_sel <= 1'b0;
         dm_mmr_index <= 5'h00;
      end else begin
         dm_ext <= '0;
         dm_mmr_sel <= dm_req.en && dm_mmr;
         dm_mmr_index <= dm_req.addr[4:0];
         if (dm_req.en && dm_rt.ext) begin
            dm_ext.sel <= 1'b1;
            dm_ext.we <= dm_req.we;
            dm_ext.addr <= ext_addr(dm_rt.msb, dm_req.addr[12:0], host_s);
            dm_ext.wdata <= {8'h00, dm_req.wdata};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // I/O and byte memory strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_bus <= '0;
      end else begin
         io_bus <= '0;
         if (io_req.en) begin
            io_bus.sel <= 1'b1;
            io_bus.we <= io_req.we;
            // Upper three lines stay low over the 2048 locations
            io_bus.addr <= ext_addr(1'b0, {2'b00, io_req.addr}, host_s);
            io_bus.wdata <= {8'h00, io_req.wdata};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_dma_port <= '0;
      end else begin
         byte_dma_port <= '0;
         if (bm_req.en) begin
            byte_dma_port.sel <= 1'b1;
            byte_dma_port.we <= bm_req.we;
            byte_dma_port.addr <= bm_req.addr;
            byte_dma_port.addr_hi <= bm_req.page;
            // Byte data rides on lines 15:8, page on lines 23:16
            byte_dma_port.wdata <= {bm_req.page, bm_req.wdata, 8'h00};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_wait_free;
      state_q == ST_WAIT_BUS && !busreq_s;
   endsequence
   sequence s_boot_then_run;
      (boot_req && bootdone_s) ##1 (core_run && !boot_req);
   endsequence

   AST_BOOT_AFTER_FREE: assert property (@(posedge pclk)
      disable iff (!presetn) s_wait_free |=> boot_req)
      else $error("boot did not start with bus free");
   AST_BOOT_TO_RUN: assert property (@(posedge pclk)
      disable iff (!presetn) (boot_req && bootdone_s) |=> core_run)
      else $error("run not entered after boot done");
   AST_STRAP_NO_BOOT: assert property (@(posedge pclk)
      disable iff (!presetn) strap_q |-> (!boot_req &&
      code_overlay_select_q == 4'h0))
      else $error("boot or overlay active with strap high");
   AST_INT_NO_EXT: assert property (@(posedge pclk)
      disable iff (!presetn) (!(pm_req.en && pm_rt.ext) &&
      !(fetch_req.en && fetch_rt.ext)) |=> !pm_ext.sel)
      else $error("external select on internal access");
   AST_OVL_ADDR: assert property (@(posedge pclk)
      disable iff (!presetn) (pm_req.en && pm_rt.ext && !strap_q && !host_s)
      |=> pm_ext.addr == {$past(code_overlay_select_q) != 4'h1,
      $past(pm_req.addr[12:0])})
      else $error("overlay address wrong");
   AST_DM_OVL: assert property (@(posedge pclk)
      disable iff (!presetn) (dm_req.en && dm_req.addr < 14'h2000 &&
      data_overlay_select_q != 4'h0) |=> dm_ext.sel)
      else $error("data overlay access not external");
   AST_RSV_FLAG: assert property (@(posedge pclk)
      disable iff (!presetn) (pm_req.en && pm_rt.rsv) |=> pm_rsv_q [*2])
      else $error("reserved program access not flagged");
   AST_IO_RANGE: assert property (@(posedge pclk)
      disable iff (!presetn) io_bus.sel |-> io_bus.addr[13:11] == 3'h0)
      else $error("I/O address above 2048 locations");
   AST_HOST_LSB: assert property (@(posedge pclk)
      disable iff (!presetn) (host_s && $stable(host_s) && pm_ext.sel)
      |-> pm_ext.addr[13:1] == 13'h0000)
      else $error("host mode drives upper address lines");
   AST_BYTE_PAGE: assert property (@(posedge pclk)
      disable iff (!presetn) bm_req.en |=>
      byte_dma_port.wdata[23:16] == $past(bm_req.page))
      else $error("byte page not on upper data lines");
   AST_BOOT_SEQ: assert property (@(posedge pclk)
      disable iff (!presetn) (boot_req && !bootdone_s) ##1 bootdone_s
      |-> s_boot_then_run)
      else $error("boot sequence broken");
endmodule
`default_nettype wire

/* core/mmap_pkg.sv */
// Constants and carrier types for the memory-space decoder.
// Assumes a single pclk domain and APB register access.
package mmap_pkg;
   ////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [11:0] OFS_CODE_OVL = 12'h000;
   localparam logic [11:0] OFS_DATA_OVL = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   // Status register bit positions
   localparam int ST_STRAP_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_PM_RSV_BIT = 2;
   localparam int ST_DM_RSV_BIT = 3;
   localparam int ST_HOST_BIT = 4;
   // Overlay select field width and reset value
   localparam int OVL_W = 4;
   localparam logic [3:0] OVL_RST = 4'h0;
   localparam logic [3:0] OVL_ONE = 4'h1;
   ////////////////////////////////////////////////////////////////////////
   // Space geometry
   localparam int PM_AW = 14;
   localparam int PM_DW = 24;
   localparam int DM_DW = 16;
   localparam int IO_AW = 11;
   localparam int BM_PAGE_W = 8;
   localparam int OVL_LOW_W = 13;
   localparam logic [13:0] UPPER_BASE = 14'h2000;
   localparam logic [13:0] MMR_BASE = 14'h3FE0;
   localparam logic [13:0] BOOT_START = 14'h0000;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic en;
      logic we;
      logic [13:0] addr;
      logic [23:0] wdata;
   } pm_req_t;
   typedef struct packed {
      logic en;
      logic we;
      logic [13:0] addr;
      logic [15:0] wdata;
   } dm_req_t;
   typedef struct packed {
      logic en;
      logic we;
      logic [10:0] addr;
      logic [15:0] wdata;
   } io_req_t;
   typedef struct packed {
      logic en;
      logic we;
      logic [7:0] page;
      logic [13:0] addr;
      logic [7:0] wdata;
   } bm_req_t;
   // Registered external strobe group; data width fits the widest space
   typedef struct packed {
      logic sel;
      logic we;
      logic [13:0] addr;
      logic [7:0] addr_hi;
      logic [23:0] wdata;
   } ext_bus_t;
   typedef struct packed {
      logic ext;
      logic rsv;
      logic msb;
   } route_t;
endpackage

/* core/pm_ram_dp.sv */
// On-chip program RAM with two independent ports.
// Assumes the core never writes the same word from both ports at once.
`timescale 1ns/1ps
`default_nettype none
module pm_ram_dp #(
   parameter int AW = 13,
   parameter int DW = 24
) (
   input wire logic pclk,
   input wire logic a_en,
   input wire logic [AW-1:0] a_addr,
   output logic [DW-1:0] a_rdata,
   input wire logic b_en,
   input wire logic b_we,
   input wire logic [AW-1:0] b_addr,
   input wire logic [DW-1:0] b_wdata,
   output logic [DW-1:0] b_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Port A serves fetch, port B serves data, both in one cycle
   always_ff @(posedge pclk) begin
      if (a_en) begin
         a_rdata <= mem[a_addr];
      end
   end

   always_ff @(posedge pclk) begin
      if (b_en) begin
         if (b_we) begin
            mem[b_addr] <= b_wdata;
         end
         b_rdata <= mem[b_addr];
      end
   end
endmodule
`default_nettype wire

/* core/sync2.sv */
// Two-flop level synchroniser for pin inputs.
// Assumes inputs are static for at least two pclk periods.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // First stage is read only by the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* dv/ovl_mem_partner.sv */
// Far-side model: boot loader and external program overlay memory.
// Assumes one-cycle decoder strobes on pclk; no external read data path.
`timescale 1ns/1ps
`default_nettype none
module ovl_mem_partner #(
   parameter int BOOT_DLY = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic boot_req,
   input wire mmap_pkg::ext_bus_t pm_ext,
   output logic boot_done,
   output logic [7:0] pm_cnt
);
   logic [7:0] dly_q;
   logic [23:0] mem_q [16384];
   ////////////////////////////////////////////////////////////////////////
   // Done stays a level once the image is in, like a real loader
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_q <= 8'h00;
         boot_done <= 1'b0;
      end else if (boot_req) begin
         dly_q <= dly_q + 8'h01;
         boot_done <= (dly_q >= 8'(BOOT_DLY));
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Both 8K segments share one array, picked by the address MSB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_cnt <= 8'h00;
      end else if (pm_ext.sel) begin
         pm_cnt <= pm_cnt + 8'h01;
         if (pm_ext.we) begin
            mem_q[pm_ext.addr] <= pm_ext.wdata;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/test_dsp_memory_map_overlay_decoder.sv */
// Testbench for the memory-space decoder: APB, overlays, boot, spaces.
// Assumes the partner model ends the boot load; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_dsp_memory_map_overlay_decoder;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, hit, fetch_stall, dm_mmr_sel;
   logic strap = 1'b0, host = 1'b0, breq = 1'b1;
   logic boot_done, boot_req, core_run;
   mmap_pkg::pm_req_t fetch_req = '0, pm_req = '0;
   mmap_pkg::dm_req_t dm_req = '0;
   mmap_pkg::io_req_t io_req = '0;
   mmap_pkg::bm_req_t bm_req = '0;
   mmap_pkg::ext_bus_t pm_ext, dm_ext, io_bus, byte_dma_port;
   logic [23:0] fetch_rdata, pm_rdata;
   logic [15:0] dm_rdata;
   logic [4:0] dm_mmr_index;
   logic [13:0] start_addr;
   logic [7:0] pm_cnt, c0;
   logic [21:0] o;
   int error_cnt = 0, compares = 0, cyc = 0, n;
   typedef struct packed {
      logic [1:0] k;
      logic [3:0] ovl;
      logic [13:0] a;
      logic hit;
      logic [13:0] ea;
   } row_t;
   row_t rows [8] = '{
      '{2'h0, 4'h1, 14'h2ABC, 1'b1, 14'h0ABC},
      '{2'h0, 4'h2, 14'h3FFF, 1'b1, 14'h3FFF},
      '{2'h0, 4'h1, 14'h1FFF, 1'b0, 14'h0000},
      '{2'h0, 4'h2, 14'h0000, 1'b0, 14'h0000},
      '{2'h1, 4'h1, 14'h0123, 1'b1, 14'h0123},
      '{2'h1, 4'h2, 14'h1FFF, 1'b1, 14'h3FFF},
      '{2'h1, 4'h1, 14'h2000, 1'b0, 14'h0000},
      '{2'h1, 4'h2, 14'h3FE5, 1'b0, 14'h0000}};
   always #5 pclk = ~pclk;
   mmap_decoder i_mmap_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_code_strap(strap), .host_mode_pin(host),
      .bus_request_pin(breq), .boot_done_pin(boot_done),
      .fetch_req(fetch_req), .pm_req(pm_req), .dm_req(dm_req),
      .io_req(io_req), .bm_req(bm_req), .fetch_rdata(fetch_rdata),
      .pm_rdata(pm_rdata), .dm_rdata(dm_rdata), .fetch_stall(fetch_stall),
      .pm_ext(pm_ext), .dm_ext(dm_ext), .io_bus(io_bus),
      .byte_dma_port(byte_dma_port), .dm_mmr_sel(dm_mmr_sel),
      .dm_mmr_index(dm_mmr_index), .boot_req(boot_req),
      .core_run(core_run), .start_addr(start_addr));
   ovl_mem_partner i_ovl_mem_partner (.pclk(pclk), .presetn(presetn),
      .boot_req(boot_req), .pm_ext(pm_ext), .boot_done(boot_done),
      .pm_cnt(pm_cnt));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle edge behind it
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // One-cycle request on space k, then watch its strobe for three edges
   task automatic go(input int k, input logic [13:0] a);
      mmap_pkg::ext_bus_t b;
      hit = 1'b0;
      o = '0;
      pm_req.addr <= a;
      dm_req.addr <= a;
      io_req.addr <= a[10:0];
      bm_req.addr <= a;
      pm_req.en <= (k == 0);
      dm_req.en <= (k == 1);
      io_req.en <= (k == 2);
      bm_req.en <= (k == 3);
      @(posedge pclk);
      pm_req.en <= 1'b0;
      dm_req.en <= 1'b0;
      io_req.en <= 1'b0;
      bm_req.en <= 1'b0;
      // The strobe launched by the request edge is looked at first
      repeat (3) begin
         #1;
         b = k == 0 ? pm_ext : k == 1 ? dm_ext : k == 2 ? io_bus :
             byte_dma_port;
         if (b.sel === 1'b1 && !hit) begin
            hit = 1'b1;
            o = {b.addr_hi, b.addr};
         end
         @(posedge pclk);
      end
      @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, mmap_pkg::OFS_CODE_OVL, 32'h0);
      chk(rd === 32'h0, "code select reset");
      repeat (4) @(posedge pclk);
      chk(boot_req === 1'b0, "boot while bus held");
      breq <= 1'b0;
      for (n = 0; n < 10 && boot_req !== 1'b1; n++) @(posedge pclk);
      chk(boot_req === 1'b1, "boot not started");
      for (n = 0; n < 40 && core_run !== 1'b1; n++) @(posedge pclk);
      chk(core_run === 1'b1 && start_addr === 14'h0000, "run");
      c0 = pm_cnt;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].k == 2'h0 ? mmap_pkg::OFS_CODE_OVL :
             mmap_pkg::OFS_DATA_OVL, {28'h0, rows[i].ovl});
         go(rows[i].k, rows[i].a);
         chk(hit === rows[i].hit, "ext select");
         if (rows[i].hit) chk(o[13:0] === rows[i].ea, "ovl addr");
      end
      chk(pm_cnt === c0 + 8'h02, "pm strobe count");
      pm_req <= '{1'b1, 1'b1, 14'h0010, 24'hABCDEF};
      dm_req <= '{1'b1, 1'b1, 14'h2005, 16'h1234};
      @(posedge pclk);
      pm_req.we <= 1'b0;
      dm_req.we <= 1'b0;
      fetch_req <= '{1'b1, 1'b0, 14'h0010, 24'h000000};
      @(posedge pclk);
      chk(fetch_stall === 1'b0, "stall on internal");
      pm_req.en <= 1'b0;
      fetch_req.en <= 1'b0;
      dm_req.en <= 1'b0;
      #1;
      chk(fetch_rdata === 24'hABCDEF, "dual fetch");
      chk(pm_rdata === 24'hABCDEF, "dual data");
      chk(dm_rdata === 16'h1234, "data ram");
      @(posedge pclk);
      pm_req <= '{1'b1, 1'b0, 14'h2000, 24'h000000};
      fetch_req <= '{1'b1, 1'b0, 14'h2001, 24'h000000};
      @(posedge pclk);
      chk(fetch_stall === 1'b1, "no stall on shared bus");
      pm_req.en <= 1'b0;
      fetch_req.en <= 1'b0;
      @(posedge pclk);
      apb(1'b0, 12'h00C, 32'h0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped");
      apb(1'b1, mmap_pkg::OFS_CODE_OVL, 32'h0);
      go(0, 14'h2100);
      chk(hit === 1'b0, "reserved went out");
      apb(1'b0, mmap_pkg::OFS_STATUS, 32'h0);
      chk(rd[mmap_pkg::ST_PM_RSV_BIT] === 1'b1, "reserved flag");
      apb(1'b1, mmap_pkg::OFS_STATUS, 32'h4);
      apb(1'b0, mmap_pkg::OFS_STATUS, 32'h0);
      chk(rd[mmap_pkg::ST_PM_RSV_BIT] === 1'b0, "flag clear");
      go(2, 14'h07FF);
      chk(hit === 1'b1 && o[10:0] === 11'h7FF, "io");
      bm_req.page <= 8'hA5;
      go(3, 14'h1234);
      chk(hit === 1'b1 && o === {8'hA5, 14'h1234}, "byte");
      host <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b1, mmap_pkg::OFS_DATA_OVL, 32'h1);
      go(1, 14'h0123);
      chk(hit === 1'b1 && o[13:0] === 14'h0001, "host addr");
      apb(1'b1, mmap_pkg::OFS_CODE_OVL, 32'h1);
      go(0, 14'h2123);
      chk(hit === 1'b1 && o[13:0] === 14'h0001, "host pm addr");
      host <= 1'b0;
      // Second reset with the external-code strap high: no boot at all
      strap <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(boot_req === 1'b0 && core_run === 1'b1, "strap boot");
      apb(1'b0, mmap_pkg::OFS_STATUS, 32'h0);
      chk(rd[mmap_pkg::ST_STRAP_BIT] === 1'b1, "strap bit");
      go(0, 14'h0100);
      chk(hit === 1'b1 && o[13:0] === 14'h0100, "strap ext");
      stop_test();
   end
endmodule
`default_nettype wire
